// ---- hw/interrupt_request_flags.sv ----
// Interrupt request flag block with APB register access and edge detection.
`timescale 1ns/1ps
`default_nettype none

module interrupt_request_flags (
	// Clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	// APB slave
	input  wire irf_pkg::irf_apb_req_t apbReq,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Event sources
	input  wire irf_pkg::irf_evt_in_t  evtIn,
	// Requests to the CPU
	output logic [7:0]                 cpuReqMain,
	output logic                       cpuReqWake,
	output logic                       irq
);
	import irf_pkg::*;

	logic [7:0]  mainFlags_r;
	logic [5:0]  wakeFlags_r;
	logic [3:0]  edgeExt_r;
	logic [5:0]  edgeWake_r;
	logic [7:0]  enable_r;
	logic [9:0]  pinFunc_r;
	logic [1:0]  sysCtl_r;
	logic [11:0] irqStat_r;
	logic [11:0] irqEn_r;
	logic [3:0]  extPrev_r;
	logic [5:0]  wakePrev_r;
	logic        pinPrimed_r;
	logic [31:0] prdata_r;
	logic [7:0]  mainSet;
	logic [5:0]  wakeSet;
	logic [11:0] evtAll;
	logic        wrAcc;
	logic        rdAcc;
	logic        addrOk;

	// Selected-edge detect; a pin is sampled as synchronous
	function automatic logic edgeHit(input logic cur, input logic prev, input logic sel);
		edgeHit = sel ? (cur & ~prev) : (~cur & prev);
	endfunction

	// Decoder shared by read and write paths
	function automatic logic isMapped(input logic [11:0] a);
		isMapped = (a == IRF_OFF_MAIN) || (a == IRF_OFF_WAKE) || (a == IRF_OFF_EDGE_EXT)
			|| (a == IRF_OFF_EDGE_WK) || (a == IRF_OFF_ENABLE) || (a == IRF_OFF_PINFUNC)
			|| (a == IRF_OFF_SYSCTL) || (a == IRF_OFF_IRQ_STAT) || (a == IRF_OFF_IRQ_CLR)
			|| (a == IRF_OFF_IRQ_EN);
	endfunction

	// Zero-wait slave: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign addrOk  = isMapped(apbReq.paddr);
	assign pslverr = apbReq.psel & apbReq.penable & ~addrOk;
	assign wrAcc   = apbReq.psel & apbReq.penable & apbReq.pwrite & addrOk;
	assign rdAcc   = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;
	assign prdata  = prdata_r;

	// Set conditions for every flag
	always_comb begin
		mainSet = 8'h00;
		mainSet[IRF_BIT_DT] = evtIn.sleepDirect & sysCtl_r[0];
		mainSet[IRF_BIT_TO] = evtIn.timerOverflow;
		wakeSet = 6'h00;
		for (int i = 0; i < 4; i++) begin
			// Pin function bit 1 means interrupt input
			mainSet[i] = pinPrimed_r & pinFunc_r[i]
				& edgeHit(evtIn.extReqPin[i], extPrev_r[i], edgeExt_r[i]);
		end
		for (int j = 0; j < 6; j++) begin
			wakeSet[j] = pinPrimed_r & pinFunc_r[4 + j]
				& edgeHit(evtIn.wakePin[j], wakePrev_r[j], edgeWake_r[j]);
		end
	end

	// Previous pin levels for edge detection; first cycle after reset primes them
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			extPrev_r   <= 4'h0;
			wakePrev_r  <= 6'h00;
			pinPrimed_r <= 1'b0;
		end else begin
			extPrev_r   <= evtIn.extReqPin;
			wakePrev_r  <= evtIn.wakePin;
			pinPrimed_r <= 1'b1;
		end
	end

	// Main flags: write 0 clears, write 1 keeps, set beats clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mainFlags_r <= IRF_RST_FLAGS;
		end else if (wrAcc && apbReq.paddr == IRF_OFF_MAIN) begin
			mainFlags_r <= (mainFlags_r & apbReq.pwdata[7:0] & ~IRF_MAIN_RSVD) | mainSet;
		end else begin
			mainFlags_r <= mainFlags_r | mainSet;
		end
	end

	// Wakeup flags are independent; only bits written as 0 clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wakeFlags_r <= 6'h00;
		end else if (wrAcc && apbReq.paddr == IRF_OFF_WAKE) begin
			wakeFlags_r <= (wakeFlags_r & apbReq.pwdata[5:0]) | wakeSet;
		end else begin
			wakeFlags_r <= wakeFlags_r | wakeSet;
		end
	end

	// Configuration registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			edgeExt_r  <= 4'h0;
			edgeWake_r <= 6'h00;
			enable_r   <= IRF_RST_CFG;
			pinFunc_r  <= 10'h000;
			sysCtl_r   <= IRF_RST_SYS;
			irqEn_r    <= 12'h000;
		end else if (wrAcc) begin
			unique case (apbReq.paddr)
				IRF_OFF_EDGE_EXT: edgeExt_r  <= apbReq.pwdata[3:0];
				IRF_OFF_EDGE_WK:  edgeWake_r <= apbReq.pwdata[5:0];
				IRF_OFF_ENABLE:   enable_r   <= apbReq.pwdata[7:0] & IRF_EN_MASK;
				// Changing pin function can raise a spurious edge; software masks first
				IRF_OFF_PINFUNC:  pinFunc_r  <= apbReq.pwdata[9:0];
				IRF_OFF_SYSCTL:   sysCtl_r   <= apbReq.pwdata[1:0];
				IRF_OFF_IRQ_EN:   irqEn_r    <= apbReq.pwdata[11:0];
				default: begin
				end
			endcase
		end
	end

	// Sticky status of raw events; clear by write-1, new event wins
	assign evtAll = {mainSet[7:6], mainSet[3:0], wakeSet};
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irqStat_r <= 12'h000;
		end else if (wrAcc && apbReq.paddr == IRF_OFF_IRQ_CLR) begin
			irqStat_r <= (irqStat_r & ~apbReq.pwdata[11:0]) | evtAll;
		end else begin
			irqStat_r <= irqStat_r | evtAll;
		end
	end

	// Read data registered in setup, presented in the access cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prdata_r <= 32'h0000_0000;
		end else if (rdAcc) begin
			unique case (apbReq.paddr)
				IRF_OFF_MAIN:     prdata_r <= {24'h0, mainFlags_r | IRF_MAIN_RSVD};
				IRF_OFF_WAKE:     prdata_r <= {24'h0, IRF_WAKE_RSVD | {2'h0, wakeFlags_r}};
				IRF_OFF_EDGE_EXT: prdata_r <= {28'h0, edgeExt_r};
				IRF_OFF_EDGE_WK:  prdata_r <= {26'h0, edgeWake_r};
				IRF_OFF_ENABLE:   prdata_r <= {24'h0, enable_r | IRF_EN_RSVD};
				IRF_OFF_PINFUNC:  prdata_r <= {22'h0, pinFunc_r};
				IRF_OFF_SYSCTL:   prdata_r <= {30'h0, sysCtl_r};
				IRF_OFF_IRQ_STAT: prdata_r <= {20'h0, irqStat_r};
				default:          prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// CPU requests gated by enables; wakeup flags share one enable
	always_comb begin
		cpuReqMain = mainFlags_r & enable_r & ~IRF_MAIN_RSVD;
		cpuReqWake = (|wakeFlags_r) & enable_r[IRF_BIT_WKEN];
	end
	assign irq = |(irqStat_r & irqEn_r);

	// Timer overflow shows in the flag on the next edge
	timer_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
		evtIn.timerOverflow |=> mainFlags_r[IRF_BIT_TO])
		else $error("timer overflow flag not set");

	// Direct transition flag set only with direct transition on
	direct_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(mainFlags_r[IRF_BIT_DT]) |-> $past(evtIn.sleepDirect) && $past(sysCtl_r[0]))
		else $error("direct transition flag set without cause");

	// External flag rises only from a selected edge in interrupt mode
	ext_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(mainFlags_r[0]) |-> $past(pinFunc_r[0]) && ($past(edgeExt_r[0])
			? $past(evtIn.extReqPin[0], 1) && !$past(evtIn.extReqPin[0], 2)
			: !$past(evtIn.extReqPin[0], 1) && $past(evtIn.extReqPin[0], 2)))
		else $error("external flag set without selected edge");

	// Main flag falls only on a write of zero
	main_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(mainFlags_r[1]) |-> $past(wrAcc) && $past(apbReq.paddr) == IRF_OFF_MAIN
			&& !$past(apbReq.pwdata[1]))
		else $error("main flag cleared without zero write");

	// Reserved bits read back as one
	rsvd_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		rdAcc && apbReq.paddr == IRF_OFF_WAKE |=> prdata[7:6] == 2'h3)
		else $error("wakeup reserved bits not one");

	// Wakeup flag falls only on a write of zero to its own bit
	wake_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(wakeFlags_r[2]) |-> $past(wrAcc) && $past(apbReq.paddr) == IRF_OFF_WAKE
			&& !$past(apbReq.pwdata[2]))
		else $error("wakeup flag cleared without zero write");

	// Set wins over a concurrent clear
	set_wins_a: assert property (@(posedge ref_clk) disable iff (rst)
		wakeSet[0] |=> wakeFlags_r[0])
		else $error("wakeup event lost");

	// Wakeup request follows the common enable
	wake_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		cpuReqWake |-> enable_r[IRF_BIT_WKEN] && wakeFlags_r != 6'h00)
		else $error("wakeup request without enable");

	// Further checks on flag setting, clearing and request gating.
	// Flags update one edge after their cause, so most checks look back one cycle.
	// Apart from edge_prime_a, the pin checks watch one bit each; the logic is the same loop for every bit,
	// so a few representative bits per pin group keep the property count small
	// without losing the edge, mode and select cases.

	// External flag rises only from a level change in interrupt mode
	ext_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(mainFlags_r[3]) |-> $past(pinPrimed_r) && $past(pinFunc_r[3])
			&& $past(evtIn.extReqPin[3]) != $past(extPrev_r[3]))
		else $error("external flag set without pin change");

	// Level after the edge matches the selected direction
	ext_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(mainFlags_r[3]) |-> $past(evtIn.extReqPin[3]) == $past(edgeExt_r[3]))
		else $error("external flag set on wrong edge");

	// A detected external edge always lands in its flag
	ext_set_a: assert property (@(posedge ref_clk) disable iff (rst)
		mainSet[2] |=> mainFlags_r[2])
		else $error("external edge lost");

	// No edge is taken before the previous levels are primed
	edge_prime_a: assert property (@(posedge ref_clk) disable iff (rst)
		!pinPrimed_r |-> mainSet[3:0] == 4'h0 && wakeSet == 6'h00)
		else $error("edge taken before priming");

	// Wakeup flag rises only from a level change in interrupt mode
	wake_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(wakeFlags_r[5]) |-> $past(pinFunc_r[9])
			&& $past(evtIn.wakePin[5]) != $past(wakePrev_r[5]))
		else $error("wakeup flag set without pin change");

	// Wakeup level after the edge matches the selected direction
	wake_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(wakeFlags_r[5]) |-> $past(evtIn.wakePin[5]) == $past(edgeWake_r[5]))
		else $error("wakeup flag set on wrong edge");

	// A detected wakeup edge always lands in its flag
	wake_set_a: assert property (@(posedge ref_clk) disable iff (rst)
		wakeSet[5] |=> wakeFlags_r[5])
		else $error("wakeup edge lost");

	// Wakeup bit 0 falls only on a write of zero to it
	wake_low_a: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(wakeFlags_r[0]) |-> $past(wrAcc) && $past(apbReq.paddr) == IRF_OFF_WAKE
			&& !$past(apbReq.pwdata[0]))
		else $error("wakeup bit 0 cleared without zero write");

	// Writing one to a wakeup bit keeps it
	wake_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
		wrAcc && apbReq.paddr == IRF_OFF_WAKE && apbReq.pwdata[3] && wakeFlags_r[3]
			|=> wakeFlags_r[3])
		else $error("wakeup flag lost on write of one");

	// Writing one to a main flag keeps it
	main_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
		wrAcc && apbReq.paddr == IRF_OFF_MAIN && apbReq.pwdata[IRF_BIT_DT]
			&& mainFlags_r[IRF_BIT_DT] |=> mainFlags_r[IRF_BIT_DT])
		else $error("main flag lost on write of one");

	// Overflow during a clearing write still sets the flag
	timer_wins_a: assert property (@(posedge ref_clk) disable iff (rst)
		evtIn.timerOverflow && wrAcc && apbReq.paddr == IRF_OFF_MAIN
			|=> mainFlags_r[IRF_BIT_TO])
		else $error("overflow lost against clear");

	// Timer flag falls only on a write of zero
	timer_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(mainFlags_r[IRF_BIT_TO]) |-> $past(wrAcc) && $past(apbReq.paddr) == IRF_OFF_MAIN
			&& !$past(apbReq.pwdata[IRF_BIT_TO]))
		else $error("timer flag cleared without zero write");

	// A cleared flag drops its request at once
	req_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(mainFlags_r[IRF_BIT_TO]) |-> !cpuReqMain[IRF_BIT_TO])
		else $error("request held after clear");

	// Main reserved bits read back as one
	main_rsvd_a: assert property (@(posedge ref_clk) disable iff (rst)
		rdAcc && apbReq.paddr == IRF_OFF_MAIN |=> prdata[5:4] == 2'h3)
		else $error("main reserved bits not one");

	// Reserved positions never hold state
	rsvd_store_a: assert property (@(posedge ref_clk) disable iff (rst)
		mainFlags_r[5:4] == 2'h0)
		else $error("reserved main bits hold state");

	// Direct transition event with the control on sets the flag
	dt_set_a: assert property (@(posedge ref_clk) disable iff (rst)
		evtIn.sleepDirect && sysCtl_r[0] |=> mainFlags_r[IRF_BIT_DT])
		else $error("direct transition event lost");

	// Direct transition control off blocks the set
	dt_off_a: assert property (@(posedge ref_clk) disable iff (rst)
		!sysCtl_r[0] |-> !mainSet[IRF_BIT_DT])
		else $error("direct transition set while off");

	// Disabled external source raises no request
	ext_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
		!enable_r[3] |-> !cpuReqMain[3])
		else $error("external request while disabled");

	// Sticky status holds until cleared
	stat_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
		irqStat_r[11] && !(wrAcc && apbReq.paddr == IRF_OFF_IRQ_CLR) |=> irqStat_r[11])
		else $error("status bit lost without clear");

	// Timer overflow always reaches the sticky status
	stat_set_a: assert property (@(posedge ref_clk) disable iff (rst)
		evtIn.timerOverflow |=> irqStat_r[10])
		else $error("overflow missing from status");

endmodule
`default_nettype wire

// ---- hw/irf_pkg.sv ----
// Package for the interrupt request flag block: offsets, field layouts, reset values.
package irf_pkg;

	// Register byte offsets on APB (word aligned)
	localparam logic [11:0] IRF_OFF_MAIN     = 12'h000;
	localparam logic [11:0] IRF_OFF_WAKE     = 12'h004;
	localparam logic [11:0] IRF_OFF_EDGE_EXT = 12'h008;
	localparam logic [11:0] IRF_OFF_EDGE_WK  = 12'h00C;
	localparam logic [11:0] IRF_OFF_ENABLE   = 12'h010;
	localparam logic [11:0] IRF_OFF_PINFUNC  = 12'h014;
	localparam logic [11:0] IRF_OFF_SYSCTL   = 12'h018;
	localparam logic [11:0] IRF_OFF_IRQ_STAT = 12'h01C;
	localparam logic [11:0] IRF_OFF_IRQ_CLR  = 12'h020;
	localparam logic [11:0] IRF_OFF_IRQ_EN   = 12'h024;

	// Field positions in the main flag register
	localparam int IRF_BIT_DT = 7;
	localparam int IRF_BIT_TO = 6;

	// Reserved bits read as one
	localparam logic [7:0] IRF_MAIN_RSVD = 8'h30;
	localparam logic [7:0] IRF_WAKE_RSVD = 8'hC0;
	// Enable register: bit 5 common wakeup enable, bit 4 reserved reads one
	localparam int         IRF_BIT_WKEN  = 5;
	localparam logic [7:0] IRF_EN_RSVD   = 8'h10;
	localparam logic [7:0] IRF_EN_MASK   = 8'hEF;

	// Reset values
	localparam logic [7:0] IRF_RST_FLAGS = 8'h00;
	localparam logic [7:0] IRF_RST_CFG   = 8'h00;
	localparam logic [1:0] IRF_RST_SYS   = 2'h0;

	// Event sources gathered for the sticky status register
	localparam int IRF_NUM_EVT = 12;

	// APB request bundle
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} irf_apb_req_t;

	// Hardware event sources
	typedef struct packed {
		logic       sleepDirect;
		logic       timerOverflow;
		logic [3:0] extReqPin;
		logic [5:0] wakePin;
	} irf_evt_in_t;

endpackage

// ---- bench/irf_cpu_model.sv ----
// CPU side stand-in: counts accepted interrupt requests.
`timescale 1ns/1ps
`default_nettype none

module irf_cpu_model (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Requests from the flag block
	input  wire logic       irq,
	// Accepted request count
	output var  logic [7:0] acceptCnt
);
	logic irqPrev;

	// Accept on each new request only; a held level is one request
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irqPrev   <= 1'b0;
			acceptCnt <= 8'h00;
		end else begin
			irqPrev <= irq;
			if (irq && !irqPrev) begin
				acceptCnt <= acceptCnt + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the interrupt request flag block.
`timescale 1ns/1ps
`default_nettype none

module tb;
	import irf_pkg::*;
	logic         ref_clk;
	logic         rst;
	irf_apb_req_t apbReq;
	irf_evt_in_t  evtIn;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic [7:0]   cpuReqMain;
	logic         cpuReqWake;
	logic         irq;
	logic [7:0]   acceptCnt;
	logic [31:0]  rd;
	logic         err;
	int           n_mismatch;
	int           total_checks;

	interrupt_request_flags i_interrupt_request_flags (.ref_clk(ref_clk), .rst(rst),
		.apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.evtIn(evtIn), .cpuReqMain(cpuReqMain), .cpuReqWake(cpuReqWake), .irq(irq));
	irf_cpu_model i_irf_cpu_model (.ref_clk(ref_clk), .rst(rst), .irq(irq),
		.acceptCnt(acceptCnt));

	// 40 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One APB transfer; waits on pready, bounded by the watchdog
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge ref_clk);
		apbReq.penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		apbReq.psel    <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask

	// Let one edge pass so combinational outputs show the last write
	task automatic settle;
		@(posedge ref_clk);
	endtask

	task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(name, rd, exp);
	endtask

	// Pulse sleep and timer event lines for one cycle
	task automatic pulse(input logic dt, input logic to);
		@(posedge ref_clk);
		evtIn.sleepDirect   <= dt;
		evtIn.timerOverflow <= to;
		@(posedge ref_clk);
		evtIn.sleepDirect   <= 1'b0;
		evtIn.timerOverflow <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask

	task automatic wrap_up;
		$display("Checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Pin switching, edge select, clears and reserved bits
	task automatic t_pins;
		rdchk("main rst", IRF_OFF_MAIN, 32'h0000_0030);
		rdchk("wake rst", IRF_OFF_WAKE, 32'h0000_00C0);
		apb(1'b1, IRF_OFF_EDGE_EXT, 32'h0000_000A);
		apb(1'b1, IRF_OFF_PINFUNC, 32'h0000_03FF); // Masked while switching
		apb(1'b0, IRF_OFF_PINFUNC, 32'h0000_0000); // One spare access first
		apb(1'b1, IRF_OFF_MAIN, 32'h0000_0000);
		apb(1'b1, IRF_OFF_WAKE, 32'h0000_0000);
		rdchk("main clr", IRF_OFF_MAIN, 32'h0000_0030);
		evtIn.extReqPin <= 4'hA;
		evtIn.wakePin   <= 6'h00;
		rdchk("ext edges", IRF_OFF_MAIN, 32'h0000_003F);
		rdchk("wake edges", IRF_OFF_WAKE, 32'h0000_00FF);
		apb(1'b1, IRF_OFF_MAIN, 32'h0000_0000);
		evtIn.extReqPin <= 4'h5;
		rdchk("wrong edge", IRF_OFF_MAIN, 32'h0000_0030);
		evtIn.extReqPin <= 4'hA;
		apb(1'b1, IRF_OFF_MAIN, 32'h0000_00FE);
		rdchk("clr bit0", IRF_OFF_MAIN, 32'h0000_003E);
		apb(1'b1, IRF_OFF_MAIN, 32'h0000_00FF);
		rdchk("write ones", IRF_OFF_MAIN, 32'h0000_003E);
		apb(1'b1, IRF_OFF_WAKE, 32'h0000_00FB);
		rdchk("wake clr2", IRF_OFF_WAKE, 32'h0000_00FB);
	endtask

	// Sleep and timer events, set against clear
	task automatic t_events;
		pulse(1'b1, 1'b0);
		rdchk("dt off", IRF_OFF_MAIN, 32'h0000_003E);
		apb(1'b1, IRF_OFF_SYSCTL, 32'h0000_0001);
		pulse(1'b1, 1'b1);
		rdchk("dt to", IRF_OFF_MAIN, 32'h0000_00FE);
		evtIn.timerOverflow <= 1'b1;
		apb(1'b1, IRF_OFF_MAIN, 32'h0000_00BE);
		evtIn.timerOverflow <= 1'b0;
		rdchk("set wins", IRF_OFF_MAIN, 32'h0000_00FE);
		apb(1'b1, IRF_OFF_MAIN, 32'h0000_00BE);
		rdchk("to clr", IRF_OFF_MAIN, 32'h0000_00BE);
	endtask

	// Enables, interrupt status, mask and unmapped access
	task automatic t_enables;
		apb(1'b1, IRF_OFF_ENABLE, 32'h0000_0081);
		settle();
		chk("req main", {24'h0, cpuReqMain}, 32'h0000_0080);
		chk("req wake off", {31'h0, cpuReqWake}, 32'h0000_0000);
		rdchk("enable rd", IRF_OFF_ENABLE, 32'h0000_0091);
		apb(1'b1, IRF_OFF_ENABLE, 32'h0000_0020);
		settle();
		chk("req main off", {24'h0, cpuReqMain}, 32'h0000_0000);
		chk("req wake", {31'h0, cpuReqWake}, 32'h0000_0001);
		apb(1'b1, IRF_OFF_IRQ_CLR, 32'h0000_0FFF);
		apb(1'b1, IRF_OFF_IRQ_EN, 32'h0000_0800);
		settle();
		chk("irq idle", {31'h0, irq}, 32'h0000_0000);
		pulse(1'b1, 1'b0);
		chk("irq set", {31'h0, irq}, 32'h0000_0001);
		rdchk("status", IRF_OFF_IRQ_STAT, 32'h0000_0800);
		apb(1'b1, IRF_OFF_IRQ_EN, 32'h0000_0000);
		settle();
		chk("irq mask", {31'h0, irq}, 32'h0000_0000);
		apb(1'b1, IRF_OFF_IRQ_CLR, 32'h0000_0800);
		apb(1'b1, IRF_OFF_IRQ_EN, 32'h0000_0800);
		settle();
		chk("irq clr", {31'h0, irq}, 32'h0000_0000);
		rdchk("clr reg", IRF_OFF_IRQ_CLR, 32'h0000_0000);
		rdchk("unmapped", 12'h100, 32'h0000_0000);
		chk("slverr", {31'h0, err}, 32'h0000_0001);
		chk("accepts", {24'h0, acceptCnt}, 32'h0000_0001);
	endtask

	// Watchdog: far beyond the roughly 130 cycles the tests need
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_mismatch++;
		wrap_up();
	end

	// Main sequence
	initial begin
		n_mismatch   = 0;
		total_checks = 0;
		rst          = 1'b1;
		apbReq       = '0;
		evtIn        = '{sleepDirect: 1'b0, timerOverflow: 1'b0, extReqPin: 4'h5,
			wakePin: 6'h3F};
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		t_pins();
		t_events();
		t_enables();
		wrap_up();
	end
endmodule
`default_nettype wire
